// ==== fhp_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module fhp_host_model
(
  // clock
  input  wire logic       ref_clk,
  // host strobes and selects
  output logic            rd_n,
  output logic            wr_n,
  output logic            cs_n,
  output logic            rsel,
  output logic            ack_n,
  output logic            rdec_n,
  output logic            odec_n,
  // data bus
  output logic      [7:0] db_in,
  input  wire logic [7:0] db_out,
  input  wire logic [7:0] db_oe
);
  // select order: cs_n, register select, ack_n, rate decode, ops decode
  localparam logic [4:0] IDLE = 5'h17;

  initial
  begin
    {cs_n, rsel, ack_n, rdec_n, odec_n} = IDLE;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    db_in = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [4:0] sel, output logic [7:0] d,
                    output logic [7:0] oe, output logic [7:0] oe_end);
    @(negedge ref_clk);
    {cs_n, rsel, ack_n, rdec_n, odec_n} = sel;
    rd_n = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    d  = db_out;
    oe = db_oe;
    @(negedge ref_clk);
    rd_n = 1'b1;
    {cs_n, rsel, ack_n, rdec_n, odec_n} = IDLE;
    // one edge only: the end-of-read pulse stands for that single cycle
    repeat (1) @(posedge ref_clk);
    #1;
    oe_end = db_oe;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // a status write is only sent when the bench wants it ignored
  task automatic wr(input logic [4:0] sel, input logic [7:0] v);
    @(negedge ref_clk);
    {cs_n, rsel, ack_n, rdec_n, odec_n} = sel;
    wr_n  = 1'b0;
    db_in = v;
    @(negedge ref_clk);
    wr_n = 1'b1;
    {cs_n, rsel, ack_n, rdec_n, odec_n} = IDLE;
    // released bus: inverse, so a stale byte cannot pass as captured
    db_in = ~v;
    // return right after the capture edge, while the write pulse stands
    repeat (1) @(posedge ref_clk);
    #1;
  endtask
endmodule

`default_nettype wire

// ==== fhp_host_port.sv ====
// Notes on behaviour
// - A rate register write keeps data bits 1:0; they select the data rate.
// - 500/250/125 kbit/s come from the fast oscillator, 300 from the slow.
// - The 8-bit main status byte is readable at any moment.
// - Four more status registers hold execution and error results.
// - Host data and status strobes count only while chip select or a counted DMA acknowledge is low.
// - A selected read drives the addressed data or status byte on the bus.
// - A selected write with register select high stores the bus byte in the data buffer.
// - Register select high picks the data buffer on writes and the sequencer data or a result status on reads; low picks the main status.
// - DMA acknowledge acts as chip select with register select high.
// - In extended mode DMA acknowledge counts only with the gate bit set.
// - Up to four drives may seek at once.
// - Disk changed and disk change read enable are active low.
// - Enable low: disk changed level goes on bit 7 in a rate decode read.
// - Each load decode with the write strobe loads two low data bits.
// - Reset idles the port, clears outputs but sets the request enables, and returns to base mode.
// - Extended mode floats DMA request unless gated; base mode drives it.
`timescale 1ns/1ns
`default_nettype none

module fhp_host_port
(
  // clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // host strobes and selects
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic       cs_n,
  input  wire logic       register_select_line,
  input  wire logic       dma_acknowledge_in_n,
  input  wire logic       rate_register_load_decode_n,
  input  wire logic       ops_register_load_decode_n,
  // data bus pin
  input  wire logic [7:0] db_in,
  output logic      [7:0] db_out,
  output logic      [7:0] db_oe,
  // disk change pins
  input  wire logic       disk_changed_input_n,
  input  wire logic       disk_change_read_enable_n,
  // oscillator ticks
  input  wire logic       osc_fast_tick,
  input  wire logic       osc_slow_tick,
  // microsequencer side
  input  wire logic [3:0] msr_flags,
  input  wire logic [7:0] seq_data,
  input  wire logic [2:0] result_sel,
  input  wire logic       status_load,
  input  wire logic [1:0] status_idx,
  input  wire logic [7:0] status_data,
  input  wire logic [3:0] seek_start,
  input  wire logic [3:0] seek_done,
  input  wire logic       dma_req_in,
  input  wire logic       irq_in,
  // results to the microsequencer
  output logic      [7:0] data_buffer,
  output logic            data_wr_pulse,
  output logic            data_rd_pulse,
  output logic      [3:0] seek_busy,
  output logic      [1:0] ops_reg,
  output logic      [1:0] rate_sel,
  output logic            bit_tick,
  output logic            ext_mode,
  // request pins
  output logic            dma_req_out,
  output logic            dma_req_oe,
  output logic            irq_out,
  output logic            irq_oe
);

  fhp_pkg::fhp_mode_t mode;
  logic [7:0] status_reg [fhp_pkg::NUM_STATUS];
  logic [7:0] db_in_q;
  logic       gate;
  logic       dma_acknowledge_in_on;
  logic       host_sel;
  logic       to_data;
  logic       rd_on;
  logic       wr_on;
  logic       wr_on_q;
  logic       to_data_q;
  logic       rd_data_q;
  logic       rate_wr;
  logic       ops_wr;
  logic       rate_wr_q;
  logic       ops_wr_q;
  logic       disk_changed_input_rd;
  logic [7:0] msr;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign gate     = ops_reg[fhp_pkg::OPS_GATE_BIT];
  // acknowledge only counts in extended mode when gated in
  assign dma_acknowledge_in_on  = !dma_acknowledge_in_n
                    && (mode == fhp_pkg::FHP_BASE || gate);
  assign host_sel = !cs_n || dma_acknowledge_in_on;
  assign to_data  = dma_acknowledge_in_on || register_select_line;
  assign rd_on    = host_sel && !rd_n;
  assign wr_on    = host_sel && !wr_n;
  assign rate_wr  = !rate_register_load_decode_n && !wr_n;
  assign ops_wr   = !ops_register_load_decode_n && !wr_n;
  assign disk_changed_input_rd  = !rd_n && !rate_register_load_decode_n
                    && !disk_change_read_enable_n;
  assign msr      = {msr_flags, seek_busy};
  assign rd_byte  = result_sel[fhp_pkg::RES_SEL_BIT]
                    ? status_reg[result_sel[1:0]] : seq_data;

  ////////////////////////////////////////////////////////////////////////////
  // strobe history; data is taken from the cycle before the strobe ends,
  // since the bus may already be released in the cycle the strobe rises

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      db_in_q   <= fhp_pkg::BYTE_RST;
      wr_on_q   <= 1'b0;
      to_data_q <= 1'b0;
      rd_data_q <= 1'b0;
      rate_wr_q <= 1'b0;
      ops_wr_q  <= 1'b0;
    end
    else if (ce)
    begin
      db_in_q   <= db_in;
      wr_on_q   <= wr_on;
      to_data_q <= to_data;
      rd_data_q <= rd_on && to_data;
      rate_wr_q <= rate_wr;
      ops_wr_q  <= ops_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data buffer; a write with register select low and no counted DMA acknowledge is dropped

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      data_buffer   <= fhp_pkg::BYTE_RST;
      data_wr_pulse <= 1'b0;
      data_rd_pulse <= 1'b0;
    end
    else if (ce)
    begin
      data_wr_pulse <= 1'b0;
      data_rd_pulse <= rd_data_q && !(rd_on && to_data);
      if (wr_on_q && !wr_on && to_data_q)
      begin
        data_buffer   <= db_in_q;
        data_wr_pulse <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate and operations registers, mode

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rate_sel <= fhp_pkg::RATE_RST;
      ops_reg  <= fhp_pkg::OPS_RST;
      mode     <= fhp_pkg::FHP_BASE;
      ext_mode <= 1'b0;
    end
    else if (ce)
    begin
      if (rate_wr_q && !rate_wr)
        rate_sel <= db_in_q[1:0];
      // loading the operations register moves the port to extended mode
      if (ops_wr_q && !ops_wr)
      begin
        ops_reg  <= db_in_q[1:0];
        mode     <= fhp_pkg::FHP_EXT;
        ext_mode <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result status registers

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < fhp_pkg::NUM_STATUS; i++)
        status_reg[i] <= fhp_pkg::BYTE_RST;
    end
    else if (ce && status_load)
      status_reg[status_idx] <= status_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // drive seek busy flags, independent per drive; start wins over done

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      seek_busy <= 4'h0;
    else if (ce)
      seek_busy <= seek_start | (seek_busy & ~seek_done);
  end

  ////////////////////////////////////////////////////////////////////////////
  // data bus drive

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      db_out <= fhp_pkg::BYTE_RST;
      db_oe  <= fhp_pkg::BYTE_RST;
    end
    else if (ce)
    begin
      if (rd_on)
      begin
        db_out <= to_data ? rd_byte : msr;
        db_oe  <= fhp_pkg::OE_ALL;
      end
      else if (disk_changed_input_rd)
      begin
        // only bit 7 is ours; the rest of the byte belongs to other logic
        db_out <= {disk_changed_input_n, 7'h00};
        db_oe  <= fhp_pkg::OE_DISK_CHANGED_INPUT;
      end
      else
      begin
        db_out <= fhp_pkg::BYTE_RST;
        db_oe  <= fhp_pkg::BYTE_RST;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request pins

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dma_req_out <= 1'b0;
      dma_req_oe  <= 1'b1;
      irq_out     <= 1'b0;
      irq_oe      <= 1'b1;
    end
    else if (ce)
    begin
      dma_req_out <= dma_req_in;
      irq_out     <= irq_in;
      dma_req_oe  <= mode == fhp_pkg::FHP_BASE || gate;
      irq_oe      <= mode == fhp_pkg::FHP_BASE || gate;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // data rate clock generation

  fhp_rate_div u_rate_div
  (
    .ref_clk       (ref_clk),
    .rstn          (rstn),
    .ce            (ce),
    .osc_fast_tick (osc_fast_tick),
    .osc_slow_tick (osc_slow_tick),
    .rate_sel      (rate_sel),
    .bit_tick      (bit_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_wr_end;
    ce && wr_on && to_data ##1 ce && !wr_on;
  endsequence

  sequence s_rate_end;
    ce && rate_wr ##1 ce && !rate_wr;
  endsequence

  property p_wr_capture;
    @(posedge ref_clk) disable iff (!rstn)
    s_wr_end |=> data_buffer == $past(db_in, 2) && data_wr_pulse;
  endproperty
  a_wr_capture: assert property (p_wr_capture)
    else $error("data buffer missed a host write");

  property p_rate_load;
    @(posedge ref_clk) disable iff (!rstn)
    s_rate_end |=> rate_sel == $past(db_in[1:0], 2);
  endproperty
  a_rate_load: assert property (p_rate_load)
    else $error("rate register missed a load");

  property p_status_read;
    @(posedge ref_clk) disable iff (!rstn)
    ce && rd_on && !to_data |=> db_out == $past(msr) && db_oe == 8'hFF;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("main status byte not driven on read");

  property p_unsel_quiet;
    @(posedge ref_clk) disable iff (!rstn)
    ce && cs_n && dma_acknowledge_in_n && !disk_changed_input_rd |=> db_oe == 8'h00;
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet)
    else $error("data bus driven without a selected read");

  property p_dma_acknowledge_in_gated;
    @(posedge ref_clk) disable iff (!rstn)
    ce && ext_mode && !gate && cs_n && !dma_acknowledge_in_n
      && !rd_n && !disk_changed_input_rd |=> db_oe == 8'h00;
  endproperty
  a_dma_acknowledge_in_gated: assert property (p_dma_acknowledge_in_gated)
    else $error("ungated acknowledge drove the bus");

  property p_dma_acknowledge_in_data;
    @(posedge ref_clk) disable iff (!rstn)
    ce && !ext_mode && !dma_acknowledge_in_n && !rd_n
      && !register_select_line |=> db_out == $past(rd_byte);
  endproperty
  a_dma_acknowledge_in_data: assert property (p_dma_acknowledge_in_data)
    else $error("acknowledged read did not return data");

  property p_dma_oe;
    @(posedge ref_clk) disable iff (!rstn)
    ce |=> dma_req_oe == (!$past(ext_mode) || $past(gate));
  endproperty
  a_dma_oe: assert property (p_dma_oe)
    else $error("request enable wrong for mode");

  property p_disk_changed_input;
    @(posedge ref_clk) disable iff (!rstn)
    ce && disk_changed_input_rd && !rd_on |=> db_oe == 8'h80
      && db_out[7] == $past(disk_changed_input_n);
  endproperty
  a_disk_changed_input: assert property (p_disk_changed_input)
    else $error("disk change level not on bit 7");

  property p_seek;
    @(posedge ref_clk) disable iff (!rstn)
    ce && seek_start == 4'hF |=> seek_busy == 4'hF;
  endproperty
  a_seek: assert property (p_seek)
    else $error("drives did not all go busy");

  property p_base_after_reset;
    @(posedge ref_clk)
    !rstn |=> !ext_mode && dma_req_oe && irq_oe;
  endproperty
  a_base_after_reset: assert property (p_base_after_reset)
    else $error("port left base mode after reset");

endmodule

`default_nettype wire

// ==== fhp_pkg.sv ====
package fhp_pkg;

  // data rate codes held in the rate register
  localparam logic [1:0] RATE_500K = 2'h0;
  localparam logic [1:0] RATE_300K = 2'h1;
  localparam logic [1:0] RATE_250K = 2'h2;
  localparam logic [1:0] RATE_125K = 2'h3;

  // oscillator figures and bit rates, in kHz
  localparam int OSC_FAST_KHZ = 16000;
  localparam int OSC_SLOW_KHZ = 9600;
  localparam int BR_500_KHZ   = 500;
  localparam int BR_300_KHZ   = 300;
  localparam int BR_250_KHZ   = 250;
  localparam int BR_125_KHZ   = 125;

  // oscillator ticks per data bit, less one
  localparam logic [7:0] DIV_500 = 8'(OSC_FAST_KHZ / BR_500_KHZ - 1);
  localparam logic [7:0] DIV_300 = 8'(OSC_SLOW_KHZ / BR_300_KHZ - 1);
  localparam logic [7:0] DIV_250 = 8'(OSC_FAST_KHZ / BR_250_KHZ - 1);
  localparam logic [7:0] DIV_125 = 8'(OSC_FAST_KHZ / BR_125_KHZ - 1);

  // operations register fields
  localparam int OPS_GATE_BIT = 1;
  localparam int OPS_AUX_BIT  = 0;

  // bus fields
  localparam int DISK_CHANGED_INPUT_BIT    = 7;
  localparam int NUM_DRIVES  = 4;
  localparam int NUM_STATUS  = 4;
  localparam int RES_SEL_BIT = 2;

  // reset values and data bus enable patterns
  localparam logic [1:0] OPS_RST  = 2'h0;
  localparam logic [1:0] RATE_RST = RATE_500K;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] OE_ALL   = 8'hFF;
  localparam logic [7:0] OE_DISK_CHANGED_INPUT  = 8'h80;

  typedef enum logic {FHP_BASE, FHP_EXT} fhp_mode_t;

endpackage

// ==== fhp_rate_div.sv ====
`timescale 1ns/1ns
`default_nettype none

module fhp_rate_div
(
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  // oscillator ticks
  input  wire logic       osc_fast_tick,
  input  wire logic       osc_slow_tick,
  // selected rate
  input  wire logic [1:0] rate_sel,
  // data bit tick
  output logic            bit_tick
);

  logic [7:0] cnt;
  logic [7:0] limit;
  logic [1:0] rate_q;
  logic       src_tick;

  always_comb
  begin
    // 300 kbit/s runs off the slow oscillator, the others off the fast
    unique case (rate_sel)
      fhp_pkg::RATE_500K:
      begin
        limit    = fhp_pkg::DIV_500;
        src_tick = osc_fast_tick;
      end
      fhp_pkg::RATE_300K:
      begin
        limit    = fhp_pkg::DIV_300;
        src_tick = osc_slow_tick;
      end
      fhp_pkg::RATE_250K:
      begin
        limit    = fhp_pkg::DIV_250;
        src_tick = osc_fast_tick;
      end
      fhp_pkg::RATE_125K:
      begin
        limit    = fhp_pkg::DIV_125;
        src_tick = osc_fast_tick;
      end
    endcase
  end

  // restart on a rate change so no shortened first bit slips through
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt      <= 8'h00;
      rate_q   <= fhp_pkg::RATE_RST;
      bit_tick <= 1'b0;
    end
    else if (ce)
    begin
      rate_q   <= rate_sel;
      bit_tick <= 1'b0;
      if (rate_q != rate_sel)
        cnt <= 8'h00;
      else if (src_tick)
      begin
        if (cnt >= limit)
        begin
          cnt      <= 8'h00;
          bit_tick <= 1'b1;
        end
        else
          cnt <= cnt + 8'h01;
      end
    end
  end

endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic       ref_clk, rstn, rd_n, wr_n, cs_n, rsel, ack_n, rdec_n, odec_n;
  logic [7:0] db_in, db_out, db_oe, d, oe, oe_end, seq_data, status_data;
  logic       disk_chg_n, disk_chg_en_n, fast, slow, status_load;
  logic       dma_req_in, irq_in, data_wr_pulse, data_rd_pulse, bit_tick;
  logic       ext_mode, dma_req_out, dma_req_oe, irq_out, irq_oe;
  logic [3:0] msr_flags, seek_start, seek_done, seek_busy;
  logic [7:0] data_buffer;
  logic [2:0] result_sel;
  logic [1:0] status_idx, ops_reg, rate_sel;
  logic [7:0] req_v, ext_v, rst_v;
  int         bad_count, checked, cycles;

  fhp_host_model u_fhp_host_model (.ref_clk(ref_clk), .rd_n(rd_n),
    .wr_n(wr_n), .cs_n(cs_n), .rsel(rsel), .ack_n(ack_n),
    .rdec_n(rdec_n), .odec_n(odec_n), .db_in(db_in), .db_out(db_out),
    .db_oe(db_oe));

  fhp_host_port u_fhp_host_port (.ref_clk(ref_clk), .rstn(rstn),
    .ce(1'b1), .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n),
    .register_select_line(rsel), .dma_acknowledge_in_n(ack_n),
    .rate_register_load_decode_n(rdec_n),
    .ops_register_load_decode_n(odec_n), .db_in(db_in), .db_out(db_out),
    .db_oe(db_oe), .disk_changed_input_n(disk_chg_n),
    .disk_change_read_enable_n(disk_chg_en_n), .osc_fast_tick(fast),
    .osc_slow_tick(slow), .msr_flags(msr_flags), .seq_data(seq_data),
    .result_sel(result_sel), .status_load(status_load),
    .status_idx(status_idx), .status_data(status_data),
    .seek_start(seek_start), .seek_done(seek_done),
    .dma_req_in(dma_req_in), .irq_in(irq_in), .data_buffer(data_buffer),
    .data_wr_pulse(data_wr_pulse), .data_rd_pulse(data_rd_pulse),
    .seek_busy(seek_busy), .ops_reg(ops_reg), .rate_sel(rate_sel),
    .bit_tick(bit_tick), .ext_mode(ext_mode), .dma_req_out(dma_req_out),
    .dma_req_oe(dma_req_oe), .irq_out(irq_out), .irq_oe(irq_oe));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // slow oscillator at half the fast rate makes the 300k period as long as the 250k one
  always @(negedge ref_clk) slow <= rstn ? ~slow : 1'b0;

  assign req_v = {4'h0, dma_req_out, irq_out, dma_req_oe, irq_oe};
  assign ext_v = {3'h0, ext_mode, ops_reg, dma_req_oe, irq_oe};
  assign rst_v = {ext_mode, rate_sel, 3'h0, dma_req_oe, irq_oe};

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] e, g);
    checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", name, e, g);
      bad_count++;
    end
  endtask

  task automatic rd(input logic [4:0] sel);
    u_fhp_host_model.rd(sel, d, oe, oe_end);
  endtask

  task automatic measure(output int n);
    n = 0;
    @(posedge ref_clk) #1;
    for (int k = 0; k < 300 && bit_tick !== 1'b1; k++) @(posedge ref_clk) #1;
    do
    begin
      @(posedge ref_clk) #1;
      n++;
    end while (bit_tick !== 1'b1 && n < 300);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_base;
    @(negedge ref_clk);
    {dma_req_in, irq_in} = 2'h3;
    repeat (2) @(posedge ref_clk) #1;
    chk("req pins", 8'h0F, req_v);
    @(negedge ref_clk);
    {dma_req_in, irq_in} = 2'h0;
  endtask

  task automatic t_seek;
    @(negedge ref_clk);
    seek_start = 4'hF;
    @(negedge ref_clk);
    seek_start = 4'h0;
    rd(5'h07);
    chk("status", 8'hAF, d);
    chk("status oe", 8'hFF, oe);
    chk("oe after", 8'h00, oe_end);
    @(negedge ref_clk);
    seek_done = 4'h5;
    @(negedge ref_clk);
    seek_done = 4'h0;
    rd(5'h07);
    chk("status done", 8'hAA, d);
  endtask

  task automatic t_write;
    u_fhp_host_model.wr(5'h0F, 8'h5A);
    chk("buffer", 8'h5A, data_buffer);
    chk("wr pulse", 8'h01, {7'h00, data_wr_pulse});
    u_fhp_host_model.wr(5'h1F, 8'hC3);
    chk("unselected wr", 8'h5A, data_buffer);
    u_fhp_host_model.wr(5'h07, 8'h3C);
    chk("status wr", 8'h5A, data_buffer);
  endtask

  task automatic t_read;
    @(negedge ref_clk);
    {status_load, status_idx, status_data} = {1'b1, 2'h3, 8'h42};
    @(negedge ref_clk);
    status_load = 1'b0;
    rd(5'h0F);
    chk("data", 8'h96, d);
    chk("rd pulse", 8'h01, {7'h00, data_rd_pulse});
    @(negedge ref_clk);
    result_sel = 3'h7;
    rd(5'h0F);
    chk("status reg", 8'h42, d);
    @(negedge ref_clk);
    result_sel = 3'h0;
    rd(5'h1F);
    chk("unselected oe", 8'h00, oe);
    rd(5'h13);
    chk("ack data", 8'h96, d);
    chk("ack oe", 8'hFF, oe);
  endtask

  task automatic t_rate;
    int n;
    logic [7:0] per [4] = '{8'h20, 8'h40, 8'h40, 8'h80};
    for (int i = 0; i < 4; i++)
    begin
      u_fhp_host_model.wr(5'h15, 8'hFC | 8'(i));
      chk("rate_sel", 8'(i), {6'h00, rate_sel});
      measure(n);
      chk("bit period", per[i], 8'(n));
    end
  endtask

  task automatic t_disk;
    @(negedge ref_clk);
    {disk_chg_n, disk_chg_en_n} = 2'h0;
    rd(5'h15);
    chk("chg oe", 8'h80, oe);
    chk("chg low", 8'h00, d & 8'h80);
    @(negedge ref_clk);
    disk_chg_n = 1'b1;
    rd(5'h15);
    chk("chg high", 8'h80, d & 8'h80);
    @(negedge ref_clk);
    disk_chg_en_n = 1'b1;
    rd(5'h15);
    chk("chg off oe", 8'h00, oe);
  endtask

  task automatic t_ext;
    u_fhp_host_model.wr(5'h16, 8'hFC);
    @(posedge ref_clk) #1;
    chk("ext gate off", 8'h10, ext_v);
    rd(5'h13);
    chk("ack ungated", 8'h00, oe);
    u_fhp_host_model.wr(5'h16, 8'h02);
    @(posedge ref_clk) #1;
    chk("ext gate on", 8'h1B, ext_v);
    rd(5'h13);
    chk("ack gated", 8'h96, d);
  endtask

  // mid-run reset from extended mode with a non-default rate
  task automatic t_reset;
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (2) @(posedge ref_clk) #1;
    chk("reset ext", 8'h03, ext_v);
    chk("reset rate", 8'h03, rst_v);
    @(negedge ref_clk);
    rstn = 1'b1;
    rd(5'h07);
    chk("status after reset", 8'hA0, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rstn, fast, status_load, dma_req_in, irq_in} = 5'h08;
    {disk_chg_n, disk_chg_en_n, result_sel, status_idx} = 7'h60;
    {msr_flags, seek_start, seek_done} = 12'hA00;
    {seq_data, status_data} = 16'h9600;
    repeat (4) @(posedge ref_clk);
    #1;
    chk("reset oe", 8'h00, db_oe);
    chk("reset mode", 8'h03, rst_v);
    chk("reset buffer", 8'h00, data_buffer);
    @(negedge ref_clk);
    rstn = 1'b1;
    t_base();
    t_seek();
    t_write();
    t_read();
    t_rate();
    t_disk();
    t_ext();
    t_reset();
    test_done();
  end
endmodule

`default_nettype wire
